/* File: hw/mgp_port.sv */
// Eight-bit pin port with timer trigger and serial muxing, Avalon-MM slave
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "mgp_map.svh"
module mgp_port #(
  parameter int PINS = 8,
  parameter int SOF_MIN_CYC = `MGP_SOF_MIN_CYC,
  parameter int SOF_CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [`MGP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire mgp_pkg::mgp_byte_t pin_in,
  output mgp_pkg::mgp_byte_t pin_out,
  output mgp_pkg::mgp_byte_t pin_oe,
  input wire logic serial_transmit_port,
  output logic serial_receive_port,
  input wire logic frame_start_pulse_n,
  output logic timer0_input,
  output logic timer1_input
);

  import mgp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by read and write paths
  function automatic mgp_reg_sel_t decode_sel(
    input logic [`MGP_ADDR_W-1:0] addr
  );
    mgp_reg_sel_t sel;
    sel = MGP_SEL_NONE;
    if (addr[1:0] == 2'b00)
    begin
      unique case (addr[`MGP_ADDR_W-1:2])
        `MGP_IDX_PIN_DIRECTION: sel = MGP_SEL_DIR;
        `MGP_IDX_PIN_OUTPUT_DATA: sel = MGP_SEL_OUT;
        `MGP_IDX_PIN_INPUT_DATA: sel = MGP_SEL_IN;
        `MGP_IDX_PIN_FUNCTION_CONFIG: sel = MGP_SEL_CFG;
        default: sel = MGP_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  mgp_bus_state_t bus_state_r;
  mgp_bus_state_t bus_state_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  mgp_byte_t pin_direction_r;
  mgp_byte_t pin_direction_nxt;
  mgp_byte_t pin_output_data_r;
  mgp_byte_t pin_output_data_nxt;
  mgp_byte_t pin_function_config_r;
  mgp_byte_t pin_function_config_nxt;
  mgp_byte_t pin_out_r;
  mgp_byte_t pin_out_nxt;
  mgp_byte_t pin_oe_r;
  mgp_byte_t pin_oe_nxt;
  logic rxd_r;
  logic rxd_nxt;
  logic t0_r;
  logic t0_nxt;
  logic t1_r;
  logic t1_nxt;
  mgp_byte_t pin_input_data;
  mgp_byte_t pin_level;
  mgp_reg_sel_t sel;
  logic req;
  logic wr_take;
  logic rd_load;
  logic sof_trigger;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input buffers, brought onto the core clock
  mgp_sync3 #(
    .WIDTH(PINS)
  ) u_pin_sync (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .async_in(pin_in),
    .sync_out(pin_input_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame start trigger with least width
  mgp_sof_stretch #(
    .MIN_CYC(SOF_MIN_CYC),
    .CNT_W(SOF_CNT_W)
  ) u_sof (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .frame_start_pulse_n(frame_start_pulse_n),
    .sof_trigger(sof_trigger)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer on the second edge
  assign req = avs_read | avs_write;
  assign sel = decode_sel(avs_address);
  assign wr_take = avs_write && (bus_state_r == MGP_BUS_ACK);
  assign rd_load = avs_read && (bus_state_r == MGP_BUS_IDLE);
  assign avs_waitrequest = req && (bus_state_r == MGP_BUS_IDLE);
  assign avs_readdata = rdata_r;

  always_comb
  begin
    bus_state_nxt = bus_state_r;
    unique case (bus_state_r)
      MGP_BUS_IDLE:
      begin
        if (req)
        begin
          bus_state_nxt = MGP_BUS_ACK;
        end
      end
      MGP_BUS_ACK:
      begin
        bus_state_nxt = MGP_BUS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the wait cycle
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (rd_load)
    begin
      rdata_nxt = '0;
      unique case (sel)
        MGP_SEL_DIR: rdata_nxt[7:0] = pin_direction_r;
        MGP_SEL_OUT: rdata_nxt[7:0] = pin_output_data_r;
        MGP_SEL_IN: rdata_nxt[7:0] = pin_input_data;
        MGP_SEL_CFG: rdata_nxt[7:0] = pin_function_config_r;
        MGP_SEL_NONE: rdata_nxt = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, low byte lane only
  always_comb
  begin
    pin_direction_nxt = pin_direction_r;
    pin_output_data_nxt = pin_output_data_r;
    pin_function_config_nxt = pin_function_config_r;
    if (wr_take && avs_byteenable[0])
    begin
      unique case (sel)
        MGP_SEL_DIR: pin_direction_nxt = avs_writedata[7:0];
        MGP_SEL_OUT: pin_output_data_nxt = avs_writedata[7:0];
        MGP_SEL_CFG:
        begin
          // Reserved upper bits stay zero
          pin_function_config_nxt =
            avs_writedata[7:0] & `MGP_CFG_WRITABLE;
        end
        MGP_SEL_IN, MGP_SEL_NONE:
        begin
          pin_function_config_nxt = pin_function_config_r;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      bus_state_r <= MGP_BUS_IDLE;
      rdata_r <= '0;
      pin_direction_r <= `MGP_RST_PIN_DIRECTION;
      pin_output_data_r <= `MGP_RST_PIN_OUTPUT_DATA;
      pin_function_config_r <= `MGP_RST_PIN_FUNCTION_CONFIG;
    end
    else if (clk_en)
    begin
      bus_state_r <= bus_state_nxt;
      rdata_r <= rdata_nxt;
      pin_direction_r <= pin_direction_nxt;
      pin_output_data_r <= pin_output_data_nxt;
      pin_function_config_r <= pin_function_config_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: data or transmit, enabled only for outputs
  generate
    for (genvar g = 0; g < PINS; g++)
    begin : g_pin
      always_comb
      begin
        pin_oe_nxt[g] = pin_direction_r[g];
        if (g == `MGP_PIN_TXD &&
            pin_function_config_r[`MGP_CFG_TXD_SEL])
        begin
          pin_out_nxt[g] = serial_transmit_port;
        end
        else
        begin
          pin_out_nxt[g] = pin_output_data_r[g];
        end
        // Driven pins loop back internally, no pad needed
        pin_level[g] = pin_direction_r[g] ?
          pin_output_data_r[g] : pin_input_data[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Timer trigger and serial receive selection
  always_comb
  begin
    t0_nxt = pin_function_config_r[`MGP_CFG_T0_SOF] ?
      sof_trigger : pin_level[`MGP_PIN_T0];
    t1_nxt = pin_function_config_r[`MGP_CFG_T1_SOF] ?
      sof_trigger : pin_level[`MGP_PIN_T1];
    rxd_nxt = pin_function_config_r[`MGP_CFG_RXD_ZERO] ?
      1'b0 : pin_input_data[`MGP_PIN_RXD];
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
      rxd_r <= 1'b0;
      t0_r <= 1'b0;
      t1_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      rxd_r <= rxd_nxt;
      t0_r <= t0_nxt;
      t1_r <= t1_nxt;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign serial_receive_port = rxd_r;
  assign timer0_input = t0_r;
  assign timer1_input = t1_r;

endmodule // mgp_port

/* File: hw/mgp_map.svh */
// Register map, field positions, reset values and timing counts of the port
`ifndef MGP_MAP_SVH
`define MGP_MAP_SVH

// Register indices; byte address is four times the index
`define MGP_IDX_PIN_DIRECTION 15'h7F18
`define MGP_IDX_PIN_OUTPUT_DATA 15'h7F19
`define MGP_IDX_PIN_INPUT_DATA 15'h7F1A
`define MGP_IDX_PIN_FUNCTION_CONFIG 15'h7F1B
`define MGP_ADDR_W 17

// Reset values
`define MGP_RST_PIN_DIRECTION 8'h00
`define MGP_RST_PIN_OUTPUT_DATA 8'h00
`define MGP_RST_PIN_FUNCTION_CONFIG 8'h00

// Function configuration fields
`define MGP_CFG_RXD_ZERO 0
`define MGP_CFG_TXD_SEL 1
`define MGP_CFG_T0_SOF 2
`define MGP_CFG_T1_SOF 3
`define MGP_CFG_WRITABLE 8'h0F

// Pin numbers with a second function
`define MGP_PIN_RXD 0
`define MGP_PIN_TXD 1
`define MGP_PIN_T0 2
`define MGP_PIN_T1 3

// Frame trigger least width
`define MGP_SOF_MIN_NS 1000
`define MGP_CLK_PERIOD_PS 5000
`define MGP_SOF_MIN_CYC \
  ((`MGP_SOF_MIN_NS * 1000 + `MGP_CLK_PERIOD_PS - 1) / `MGP_CLK_PERIOD_PS)

`endif

/* File: hw/mgp_pkg.sv */
// Types shared by the pin port modules
package mgp_pkg;

  typedef logic [7:0] mgp_byte_t;

  typedef enum logic [2:0]
  {
    MGP_SEL_NONE = 3'b000,
    MGP_SEL_DIR = 3'b001,
    MGP_SEL_OUT = 3'b010,
    MGP_SEL_IN = 3'b011,
    MGP_SEL_CFG = 3'b100
  } mgp_reg_sel_t;

  typedef enum logic
  {
    MGP_BUS_IDLE = 1'b0,
    MGP_BUS_ACK = 1'b1
  } mgp_bus_state_t;

endpackage

/* File: hw/mgp_sync3.sv */
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module mgp_sync3 #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] out_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // A bit changes only once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end
    else if (clk_en)
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;

endmodule // mgp_sync3

/* File: hw/mgp_sof_stretch.sv */
// Stretches the frame start strobe to a least active width
`timescale 1ns/1ps
module mgp_sof_stretch #(
  parameter int MIN_CYC = 200,
  parameter int CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic frame_start_pulse_n,
  output logic sof_trigger
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Every strobe reloads, so the trigger never ends early
  always_comb
  begin
    if (!frame_start_pulse_n)
    begin
      cnt_nxt = CNT_W'(MIN_CYC);
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
    else
    begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cnt_r <= '0;
    end
    else if (clk_en)
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign sof_trigger = (cnt_r != '0);

endmodule // mgp_sof_stretch

/* File: verification/mgp_port_properties.sv */
// Concurrent checks on the pin port bus, pads and timer outputs
`timescale 1ns/1ps
`include "mgp_map.svh"
module mgp_port_properties (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic [`MGP_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire mgp_pkg::mgp_byte_t pin_in,
  input wire mgp_pkg::mgp_byte_t pin_out,
  input wire mgp_pkg::mgp_byte_t pin_oe,
  input wire logic serial_transmit_port,
  input wire logic serial_receive_port,
  input wire logic frame_start_pulse_n,
  input wire logic timer0_input,
  input wire logic timer1_input
);
  import mgp_pkg::*;
  localparam logic [16:0] A_DIR = {`MGP_IDX_PIN_DIRECTION, 2'b00};
  localparam logic [16:0] A_OUT = {`MGP_IDX_PIN_OUTPUT_DATA, 2'b00};
  localparam logic [16:0] A_CFG = {`MGP_IDX_PIN_FUNCTION_CONFIG, 2'b00};
  logic wr_ok;
  logic rd_ok;
  logic [3:0] cfg_r;
  logic [3:0] cfg_nxt;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ok = avs_read && !avs_waitrequest;
  // Shadow of the writable config bits
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (wr_ok && avs_address == A_CFG)
      cfg_nxt = avs_writedata[3:0];
  end
  always_ff @(posedge core_clk)
  begin
    if (srst)
      cfg_r <= 4'h0;
    else if (clk_en)
      cfg_r <= cfg_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_stretch(sig);
    ##2 sig [*4];
  endsequence
  property p_wait;
    (avs_read || avs_write) && !$past(avs_read || avs_write)
      |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait cycle wrong");
  property p_dir;
    wr_ok && avs_address == A_DIR |-> ##2 pin_oe == $past(avs_writedata[7:0], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("oe bad");
  property p_out;
    wr_ok && avs_address == A_OUT
      |-> ##2 {pin_out[7:2], pin_out[0]} == $past({avs_writedata[7:2],
      avs_writedata[0]}, 2);
  endproperty
  a_out: assert property (p_out) else $error("out bad");
  property p_rdhi;
    rd_ok |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_rdhi: assert property (p_rdhi) else $error("rd high");
  property p_rsvd;
    rd_ok && avs_address == A_CFG |-> avs_readdata[7:4] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("rsvd");
  property p_t0;
    cfg_r[2] && !frame_start_pulse_n |-> s_stretch(timer0_input);
  endproperty
  a_t0: assert property (p_t0) else $error("t0 frame");
  property p_t1;
    cfg_r[3] && !frame_start_pulse_n |-> s_stretch(timer1_input);
  endproperty
  a_t1: assert property (p_t1) else $error("t1 frame");
  property p_rx;
    cfg_r[0] && $past(cfg_r[0]) |-> !serial_receive_port;
  endproperty
  a_rx: assert property (p_rx) else $error("rx not zero");
  property p_tx;
    cfg_r[1] && $past(cfg_r[1]) |-> pin_out[1] == $past(serial_transmit_port);
  endproperty
  a_tx: assert property (p_tx) else $error("tx mux");
endmodule // mgp_port_properties
bind mgp_port mgp_port_properties i_props (.core_clk, .srst, .clk_en,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe,
  .serial_transmit_port, .serial_receive_port, .frame_start_pulse_n,
  .timer0_input, .timer1_input);

/* File: verification/mgp_pad_model.sv */
// Pad model: a pin shows the port drive when enabled, else the outside level
`timescale 1ns/1ps
module mgp_pad_model (
  input wire mgp_pkg::mgp_byte_t pin_out,
  input wire mgp_pkg::mgp_byte_t pin_oe,
  input wire mgp_pkg::mgp_byte_t ext_level,
  output mgp_pkg::mgp_byte_t pin_in
);
  import mgp_pkg::*;
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // mgp_pad_model

/* File: verification/mgp_port_tb.sv */
// Self-checking bench for the pin port
`timescale 1ns/1ps
`include "mgp_map.svh"
module mgp_port_tb;
  import mgp_pkg::*;
  typedef struct packed
  {
    logic [16:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } mgp_row_t;
  localparam logic [16:0] A_DIR = {`MGP_IDX_PIN_DIRECTION, 2'b00};
  localparam logic [16:0] A_OUT = {`MGP_IDX_PIN_OUTPUT_DATA, 2'b00};
  localparam logic [16:0] A_IN = {`MGP_IDX_PIN_INPUT_DATA, 2'b00};
  localparam logic [16:0] A_CFG = {`MGP_IDX_PIN_FUNCTION_CONFIG, 2'b00};
  localparam int SOF = 4;
  logic core_clk, srst, clk_en, avs_read, avs_write, tx, frame_n, rx, t0, t1;
  logic avs_waitrequest;
  logic [16:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  mgp_byte_t pin_in, pin_out, pin_oe, ext;
  logic [7:0] q;
  int error_cnt = 0;
  int n_checks = 0;
  mgp_row_t rows [5] = '{'{A_DIR | 17'h0_0001, 8'hFF, 8'h00},
    '{A_DIR, 8'hA5, 8'hA5}, '{A_OUT, 8'h3C, 8'h3C},
    '{A_CFG, 8'hFF, 8'h0F}, '{{15'h7F1C, 2'b00}, 8'h12, 8'h00}};
  mgp_port #(.SOF_MIN_CYC(SOF)) i_dut (.core_clk, .srst, .clk_en,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe,
    .serial_transmit_port(tx), .serial_receive_port(rx),
    .frame_start_pulse_n(frame_n), .timer0_input(t0), .timer1_input(t1));
  mgp_pad_model i_pads (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Holds the request until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      error_cnt++;
      report_and_stop();
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [16:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    srst = 1'b1;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 17'h0_0000;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    ext = 8'h00;
    tx = 1'b0;
    frame_n = 1'b1;
    cyc(3);
    srst <= 1'b0;
    chk(pin_oe, 8'h00);
    rd(A_DIR, 8'h00);
    rd(A_OUT, 8'h00);
    rd(A_CFG, 8'h00);
    avs_byteenable <= 4'h0;
    wr(A_OUT, 8'hFF);
    avs_byteenable <= 4'h1;
    rd(A_OUT, 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("test registers done");
    wr(A_CFG, 8'h00);
    wr(A_DIR, 8'h00);
    ext <= 8'h96;
    cyc(8);
    chk(pin_oe, 8'h00);
    rd(A_IN, 8'h96);
    wr(A_IN, 8'h00);
    wr(A_OUT, 8'h0A);
    wr(A_DIR, 8'h0F);
    cyc(8);
    chk(pin_oe, 8'h0F);
    rd(A_IN, 8'h9A);
    chk({6'h00, t1, t0}, 8'h02);
    wr(A_OUT, 8'h04);
    cyc(3);
    chk({6'h00, t1, t0}, 8'h01);
    $display("test pads done");
    wr(A_DIR, 8'h00);
    ext <= 8'h09;
    cyc(8);
    chk({6'h00, t1, t0}, 8'h02);
    chk({7'h00, rx}, 8'h01);
    wr(A_CFG, 8'h0D);
    cyc(3);
    chk({7'h00, rx}, 8'h00);
    frame_n <= 1'b0;
    cyc(1);
    frame_n <= 1'b1;
    cyc(3);
    chk({6'h00, t1, t0}, 8'h03);
    cyc(SOF + 4);
    chk({6'h00, t1, t0}, 8'h00);
    $display("test frame done");
    wr(A_CFG, 8'h02);
    wr(A_DIR, 8'h02);
    tx <= 1'b1;
    cyc(3);
    chk({7'h00, pin_out[1]}, 8'h01);
    tx <= 1'b0;
    cyc(3);
    chk({7'h00, pin_out[1]}, 8'h00);
    wr(A_CFG, 8'h00);
    wr(A_OUT, 8'h02);
    cyc(3);
    chk({7'h00, pin_out[1]}, 8'h01);
    $display("test serial done");
    clk_en <= 1'b0;
    ext <= 8'h04;
    cyc(8);
    chk({6'h00, t1, t0}, 8'h02);
    clk_en <= 1'b1;
    cyc(8);
    chk({6'h00, t1, t0}, 8'h01);
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    chk(pin_oe, 8'h00);
    rd(A_OUT, 8'h00);
    rd(A_CFG, 8'h00);
    $display("test enable and reset done");
    report_and_stop();
  end
endmodule // mgp_port_tb
